// ### bakp_pkg.sv
package bakp_pkg;
  // word addresses of the register map (16-bit register words)
  localparam logic [15:0] ADDR_ACCESS_KEY_HI = 16'h0040;
  localparam logic [15:0] ADDR_ACCESS_KEY_LO = 16'h0041;
  localparam logic [15:0] ADDR_WRITE_KEY_HI = 16'h0042;
  localparam logic [15:0] ADDR_WRITE_KEY_LO = 16'h0043;
  localparam logic [15:0] ADDR_RESTORE_HI = 16'h0196;
  localparam logic [15:0] ADDR_RESTORE_LO = 16'h0197;
  localparam logic [15:0] ADDR_STORE_HI = 16'h0198;
  localparam logic [15:0] ADDR_STORE_LO = 16'h0199;
  // network command codes
  localparam logic [15:0] NET_RD_ACCESS_KEY = 16'h0020;
  localparam logic [15:0] NET_RD_WRITE_KEY = 16'h0021;
  localparam logic [15:0] NET_WR_ACCESS_KEY = 16'h1020;
  localparam logic [15:0] NET_WR_WRITE_KEY = 16'h1021;
  localparam logic [15:0] NET_RESTORE = 16'h30CB;
  localparam logic [15:0] NET_STORE = 16'h30CC;
  // key codes and reset values
  localparam logic [31:0] ACCESS_KEY_CODE = 32'h01391955;
  localparam logic [31:0] WRITE_KEY_CODE = 32'h75DB9C97;
  localparam logic [31:0] KEY_RESET = 32'h00000000;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [15:0] data;
  } bakp_mb_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] code;
    logic [31:0] data;
  } bakp_net_req_t;

  typedef struct packed {
    logic        valid;
    logic        error;
    logic [31:0] data;
  } bakp_rsp_t;

  typedef enum logic [1:0] {
    BAKP_IDLE    = 2'b00,
    BAKP_COPY    = 2'b01,
    BAKP_DONE    = 2'b11
  } bakp_state_t;
endpackage

// ### bakp_copier.sv
`timescale 1ns/1ps
// walks every word of the working set, copying in the chosen direction
module bakp_copier #(
  parameter int AW = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic to_backup,
  output logic busy,
  output logic done,
  // memory walk
  output logic [AW-1:0] word_addr,
  output logic copy_en,
  output logic copy_dir_store
);
  bakp_pkg::bakp_state_t state_q, state_d;
  logic [AW-1:0] addr_q, addr_d;
  logic dir_q, dir_d;

  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    dir_d = dir_q;
    case (state_q)
      bakp_pkg::BAKP_IDLE: begin
        if (start) begin
          state_d = bakp_pkg::BAKP_COPY;
          addr_d = '0;
          dir_d = to_backup;
        end
      end
      bakp_pkg::BAKP_COPY: begin
        addr_d = addr_q + AW'(1);
        if (&addr_q) begin
          state_d = bakp_pkg::BAKP_DONE;
        end
      end
      bakp_pkg::BAKP_DONE: state_d = bakp_pkg::BAKP_IDLE;
      default: state_d = bakp_pkg::BAKP_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= bakp_pkg::BAKP_IDLE;
      addr_q <= '0;
      dir_q <= 1'b0;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      dir_q <= dir_d;
    end
  end

  assign busy = (state_q != bakp_pkg::BAKP_IDLE);
  assign done = (state_q == bakp_pkg::BAKP_DONE);
  assign word_addr = addr_q;
  assign copy_en = (state_q == bakp_pkg::BAKP_COPY);
  assign copy_dir_store = dir_q;
endmodule

// ### bakp_key_protect.sv
`timescale 1ns/1ps
module bakp_key_protect #(
  parameter int AW = 6,
  parameter int DW = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial register port
  input wire bakp_pkg::bakp_mb_req_t mb_req,
  output bakp_pkg::bakp_rsp_t mb_rsp,
  // network command port
  input wire bakp_pkg::bakp_net_req_t net_req,
  output bakp_pkg::bakp_rsp_t net_rsp,
  // working data set, one word per address
  input wire logic work_we,
  input wire logic [AW-1:0] work_addr,
  input wire logic [DW-1:0] work_wdata,
  output logic [DW-1:0] work_rdata,
  // status
  output logic busy,
  output logic refused
);
  logic [DW-1:0] work_mem [2**AW];
  logic [DW-1:0] bkup_mem [2**AW];
  logic [31:0] akey_q, akey_d, wkey_q, wkey_d;
  bakp_pkg::bakp_rsp_t mb_rsp_q, mb_rsp_d, net_rsp_q, net_rsp_d;
  logic refused_q, refused_d;
  logic start, to_backup, copy_en, dir_store, cp_busy;
  logic [AW-1:0] cp_addr;
  logic store_ok, restore_ok;
  logic cmd_hit, cmd_bad;
  logic bk_we, wk_we;
  logic [AW-1:0] wk_addr;
  logic [DW-1:0] wk_data, work_rdata_d;

  function automatic logic [31:0] set_half(input logic [31:0] v,
                                           input logic hi,
                                           input logic [15:0] d);
    set_half = hi ? {d, v[15:0]} : {v[31:16], d};
  endfunction

  // upper half sits at the even word, lower half at the odd one
  function automatic logic [15:0] get_half(input logic [31:0] v,
                                           input logic lo);
    get_half = lo ? v[15:0] : v[31:16];
  endfunction

  // both words of a key register share all but the lowest address bit
  function automatic logic is_key_word(input logic [15:0] a,
                                       input logic [15:0] hi);
    is_key_word = (a[15:1] == hi[15:1]);
  endfunction

  assign restore_ok = (akey_q == bakp_pkg::ACCESS_KEY_CODE);
  assign store_ok = restore_ok &&
                    (wkey_q == bakp_pkg::WRITE_KEY_CODE);

  always_comb begin
    cmd_hit = 1'b0;
    cmd_bad = 1'b0;
    start = 1'b0;
    to_backup = 1'b0;
    mb_rsp_d = '0;
    net_rsp_d = '0;
    if (mb_req.valid) begin
      mb_rsp_d.valid = 1'b1;
      case (mb_req.addr)
        bakp_pkg::ADDR_ACCESS_KEY_HI, bakp_pkg::ADDR_ACCESS_KEY_LO: begin
          mb_rsp_d.data = {16'h0000, get_half(akey_q, mb_req.addr[0])};
        end
        bakp_pkg::ADDR_WRITE_KEY_HI, bakp_pkg::ADDR_WRITE_KEY_LO: begin
          mb_rsp_d.data = {16'h0000, get_half(wkey_q, mb_req.addr[0])};
        end
        bakp_pkg::ADDR_RESTORE_HI, bakp_pkg::ADDR_RESTORE_LO: begin
          // write-only: a read answers with an error
          mb_rsp_d.error = !mb_req.write || cp_busy || !restore_ok;
          start = mb_req.write && !cp_busy && restore_ok;
          cmd_hit = 1'b1;
          cmd_bad = mb_req.write && !restore_ok;
        end
        bakp_pkg::ADDR_STORE_HI, bakp_pkg::ADDR_STORE_LO: begin
          mb_rsp_d.error = !mb_req.write || cp_busy || !store_ok;
          start = mb_req.write && !cp_busy && store_ok;
          to_backup = 1'b1;
          cmd_hit = 1'b1;
          cmd_bad = mb_req.write && !store_ok;
        end
        default: mb_rsp_d.error = 1'b1;
      endcase
    end else if (net_req.valid) begin
      // serial port wins when both arrive together
      net_rsp_d.valid = 1'b1;
      case (net_req.code)
        bakp_pkg::NET_RD_ACCESS_KEY: net_rsp_d.data = akey_q;
        bakp_pkg::NET_RD_WRITE_KEY: net_rsp_d.data = wkey_q;
        bakp_pkg::NET_WR_ACCESS_KEY, bakp_pkg::NET_WR_WRITE_KEY: ;
        bakp_pkg::NET_RESTORE: begin
          net_rsp_d.error = cp_busy || !restore_ok;
          start = !cp_busy && restore_ok;
          cmd_hit = 1'b1;
          cmd_bad = !restore_ok;
        end
        bakp_pkg::NET_STORE: begin
          net_rsp_d.error = cp_busy || !store_ok;
          start = !cp_busy && store_ok;
          to_backup = 1'b1;
          cmd_hit = 1'b1;
          cmd_bad = !store_ok;
        end
        default: net_rsp_d.error = 1'b1;
      endcase
    end
  end

  // key registers: the serial port wins over the network port, so a key
  // sent on both ports in one cycle takes the serial value
  always_comb begin
    akey_d = akey_q;
    wkey_d = wkey_q;
    if (mb_req.valid && mb_req.write) begin
      if (is_key_word(mb_req.addr, bakp_pkg::ADDR_ACCESS_KEY_HI)) begin
        akey_d = set_half(akey_q, !mb_req.addr[0], mb_req.data);
      end
      if (is_key_word(mb_req.addr, bakp_pkg::ADDR_WRITE_KEY_HI)) begin
        wkey_d = set_half(wkey_q, !mb_req.addr[0], mb_req.data);
      end
    end else if (!mb_req.valid && net_req.valid) begin
      if (net_req.code == bakp_pkg::NET_WR_ACCESS_KEY) begin
        akey_d = net_req.data;
      end
      if (net_req.code == bakp_pkg::NET_WR_WRITE_KEY) begin
        wkey_d = net_req.data;
      end
    end
  end

  // refused follows the last command word touched: bad keys set it, an
  // accepted command or a read of a command word clears it
  always_comb begin
    refused_d = refused_q;
    if (cmd_hit) begin
      refused_d = cmd_bad;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      akey_q <= bakp_pkg::KEY_RESET;
      wkey_q <= bakp_pkg::KEY_RESET;
      refused_q <= 1'b0;
      mb_rsp_q <= '0;
      net_rsp_q <= '0;
    end else begin
      akey_q <= akey_d;
      wkey_q <= wkey_d;
      refused_q <= refused_d;
      mb_rsp_q <= mb_rsp_d;
      net_rsp_q <= net_rsp_d;
    end
  end

  bakp_copier #(.AW(AW)) u_copier (
    .clk(clk),
    .rst(rst),
    .start(start),
    .to_backup(to_backup),
    .busy(cp_busy),
    .done(),
    .word_addr(cp_addr),
    .copy_en(copy_en),
    .copy_dir_store(dir_store)
  );

  // user writes are dropped during a copy so the set stays consistent;
  // a user must wait for busy to fall, there is no queue
  always_comb begin
    bk_we = copy_en && dir_store;
    wk_we = 1'b0;
    wk_addr = work_addr;
    wk_data = work_wdata;
    if (copy_en && !dir_store) begin
      wk_we = 1'b1;
      wk_addr = cp_addr;
      wk_data = bkup_mem[cp_addr];
    end else if (work_we && !cp_busy) begin
      wk_we = 1'b1;
    end
  end

  // memories are not reset: their contents mean nothing until written
  always_ff @(posedge clk) begin
    if (bk_we) begin
      bkup_mem[cp_addr] <= work_mem[cp_addr];
    end
    if (wk_we) begin
      work_mem[wk_addr] <= wk_data;
    end
  end

  always_comb begin
    work_rdata_d = work_mem[work_addr];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      work_rdata <= '0;
    end else begin
      work_rdata <= work_rdata_d;
    end
  end

  assign mb_rsp = mb_rsp_q;
  assign net_rsp = net_rsp_q;
  assign busy = cp_busy;
  assign refused = refused_q;
endmodule

// ### bakp_host.sv
`timescale 1ns/1ps
module bakp_host (
  // clock and answers
  input wire logic clk,
  input wire bakp_pkg::bakp_rsp_t mb_rsp,
  input wire bakp_pkg::bakp_rsp_t net_rsp,
  // requests
  output bakp_pkg::bakp_mb_req_t mb_req,
  output bakp_pkg::bakp_net_req_t net_req
);
  initial begin
    mb_req = '0;
    net_req = '0;
  end
  // answer is taken one cycle after the request edge
  task automatic mb(input logic w, input logic [15:0] a, d,
                    output bakp_pkg::bakp_rsp_t r);
    @(negedge clk);
    mb_req <= {1'b1, w, a, d};
    @(negedge clk);
    r = mb_rsp;
    // released lines carry junk so stale values cannot pass
    mb_req <= {1'b0, ~w, ~a, ~d};
  endtask
  task automatic net(input logic [15:0] c, input logic [31:0] d,
                     output bakp_pkg::bakp_rsp_t r);
    @(negedge clk);
    net_req <= {1'b1, c, d};
    @(negedge clk);
    r = net_rsp;
    net_req <= {1'b0, ~c, ~d};
  endtask
endmodule

// ### bakp_key_protect_asserts.sv
`timescale 1ns/1ps
module bakp_key_protect_chk (
  // watched ports
  input wire logic clk,
  input wire logic rst,
  input wire bakp_pkg::bakp_mb_req_t mb_req,
  input wire bakp_pkg::bakp_rsp_t mb_rsp,
  input wire bakp_pkg::bakp_net_req_t net_req,
  input wire bakp_pkg::bakp_rsp_t net_rsp,
  input wire logic busy,
  input wire logic refused
);
  logic [31:0] ak_q, wk_q;
  logic [15:0] ak_hi, wk_lo;
  logic mw, mr, nw, ok_r, ok_s, cmd_r, cmd_s;
  assign mw = mb_req.valid && mb_req.write;
  assign mr = mb_req.valid && !mb_req.write;
  assign nw = net_req.valid && !mb_req.valid;
  assign ak_hi = ak_q[31:16];
  assign wk_lo = wk_q[15:0];
  assign ok_r = ak_q == bakp_pkg::ACCESS_KEY_CODE;
  assign ok_s = ok_r && wk_q == bakp_pkg::WRITE_KEY_CODE;
  assign cmd_r = mw && !busy && mb_req.addr[15:1] == 15'h00CB;
  assign cmd_s = mw && !busy && mb_req.addr[15:1] == 15'h00CC;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ak_q <= '0;
      wk_q <= '0;
    end else if (mw) begin
      case (mb_req.addr)
        bakp_pkg::ADDR_ACCESS_KEY_HI: ak_q[31:16] <= mb_req.data;
        bakp_pkg::ADDR_ACCESS_KEY_LO: ak_q[15:0] <= mb_req.data;
        bakp_pkg::ADDR_WRITE_KEY_HI: wk_q[31:16] <= mb_req.data;
        bakp_pkg::ADDR_WRITE_KEY_LO: wk_q[15:0] <= mb_req.data;
        default: ;
      endcase
    end else if (nw && net_req.code == bakp_pkg::NET_WR_ACCESS_KEY) begin
      ak_q <= net_req.data;
    end else if (nw && net_req.code == bakp_pkg::NET_WR_WRITE_KEY) begin
      wk_q <= net_req.data;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_mb_answer: assert property (mb_req.valid |=> mb_rsp.valid)
    else $error("register request not answered");
  chk_store_go: assert property (cmd_s && ok_s |=> busy && !refused)
    else $error("store with good keys not started");
  chk_restore_go: assert property (cmd_r && ok_r |=> busy && !refused)
    else $error("restore with good key not started");
  chk_store_block: assert property (cmd_s && !ok_s |=> refused && !busy)
    else $error("store with bad keys not refused");
  chk_restore_block: assert property (cmd_r && !ok_r
    |=> refused && !busy ##1 !busy)
    else $error("restore with bad key started");
  chk_bad_error: assert property ((cmd_r && !ok_r) |=> mb_rsp.error)
    else $error("refused restore without error");
  chk_akey_read: assert property (mr && mb_req.addr == 16'h0040
    |=> mb_rsp.data[15:0] == $past(ak_hi))
    else $error("access key upper word wrong");
  chk_wkey_read: assert property (mr && mb_req.addr == 16'h0043
    |=> mb_rsp.data[15:0] == $past(wk_lo))
    else $error("write key lower word wrong");
  chk_net_read: assert property (nw && net_req.code == 16'h0021
    |=> net_rsp.valid && net_rsp.data == $past(wk_q))
    else $error("network key read wrong");
endmodule
bind bakp_key_protect bakp_key_protect_chk i_chk (.clk(clk), .rst(rst),
  .mb_req(mb_req), .mb_rsp(mb_rsp), .net_req(net_req),
  .net_rsp(net_rsp), .busy(busy), .refused(refused));

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk = 0;
  logic rst = 1;
  logic work_we = 0;
  logic [5:0] work_addr = '0;
  logic [31:0] work_wdata = '0;
  logic [31:0] work_rdata;
  logic busy, refused;
  bakp_pkg::bakp_mb_req_t mb_req;
  bakp_pkg::bakp_net_req_t net_req;
  bakp_pkg::bakp_rsp_t mb_rsp, net_rsp, r;
  int error_cnt = 0;
  int samples_checked = 0;
  bakp_key_protect i_dut (.clk(clk), .rst(rst), .mb_req(mb_req),
    .mb_rsp(mb_rsp), .net_req(net_req), .net_rsp(net_rsp),
    .work_we(work_we), .work_addr(work_addr), .work_wdata(work_wdata),
    .work_rdata(work_rdata), .busy(busy), .refused(refused));
  bakp_host i_host (.clk(clk), .mb_rsp(mb_rsp), .net_rsp(net_rsp),
    .mb_req(mb_req), .net_req(net_req));
  initial forever #10 clk = ~clk;
  task automatic check(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic rd(input logic [15:0] a, e);
    i_host.mb(1'b0, a, 16'h0000, r);
    check("key word", 32'({r.valid, r.error, r.data[15:0]}), 32'({2'b10, e}));
  endtask
  task automatic wr(input logic [15:0] a, d, input logic er);
    i_host.mb(1'b1, a, d, r);
    check("write answer", 32'({r.valid, r.error}), 32'({1'b1, er}));
  endtask
  task automatic fill(input logic [31:0] b);
    for (int i = 0; i < 64; i++) begin
      @(negedge clk);
      work_we = 1'b1;
      work_addr = 6'(i);
      work_wdata = b + 32'(i);
    end
    @(negedge clk);
    work_we = 1'b0;
  endtask
  task automatic idle;
    for (int i = 0; i < 100 && busy !== 1'b0; i++) @(negedge clk);
    check("busy", 32'(busy), 32'h0);
  endtask
  initial begin
    #100us;
    error_cnt++;
    final_report;
  end
  initial begin
    repeat (3) @(negedge clk);
    rst = 0;
    rd(16'h0040, 16'h0000);
    rd(16'h0043, 16'h0000);
    wr(16'h0050, 16'h1234, 1'b1);
    fill(32'hA5000000);
    wr(16'h0199, 16'h0000, 1'b1);
    check("refused", 32'(refused), 32'h1);
    wr(16'h0196, 16'h0000, 1'b1);
    // access key goes in after the first store and restore were refused
    wr(16'h0040, 16'h0139, 1'b0);
    wr(16'h0041, 16'h1955, 1'b0);
    rd(16'h0040, 16'h0139);
    wr(16'h0198, 16'h0000, 1'b1);
    i_host.net(bakp_pkg::NET_WR_WRITE_KEY, bakp_pkg::WRITE_KEY_CODE,
      r);
    i_host.net(bakp_pkg::NET_RD_WRITE_KEY, 32'h0, r);
    check("net key", r.data, bakp_pkg::WRITE_KEY_CODE);
    rd(16'h0042, 16'h75DB);
    wr(16'h0198, 16'h0000, 1'b0);
    check("busy", 32'(busy), 32'h1);
    check("refused", 32'(refused), 32'h0);
    idle();
    i_host.mb(1'b0, 16'h0196, 16'h0000, r);
    check("cmd read", 32'({r.valid, r.error}), 32'h3);
    fill(32'h00000000);
    i_host.net(bakp_pkg::NET_RESTORE, 32'h0, r);
    check("net restore", 32'({r.valid, r.error}), 32'h2);
    idle();
    for (int i = 0; i < 64; i++) begin
      @(negedge clk);
      work_addr = 6'(i);
      @(negedge clk);
      check("work", work_rdata, 32'hA5000000 + 32'(i));
    end
    i_host.net(bakp_pkg::NET_RD_ACCESS_KEY, 32'h0, r);
    check("net akey", r.data, bakp_pkg::ACCESS_KEY_CODE);
    i_host.net(bakp_pkg::NET_STORE, 32'h0, r);
    check("net store", 32'({r.valid, r.error}), 32'h2);
    idle();
    // a refused store must leave this pattern out of the backup area
    fill(32'h5A000000);
    i_host.net(bakp_pkg::NET_WR_ACCESS_KEY, 32'h0, r);
    i_host.net(bakp_pkg::NET_STORE, 32'h0, r);
    check("bad store", 32'({r.valid, r.error}), 32'h3);
    check("refused", 32'(refused), 32'h1);
    i_host.net(16'h0000, 32'h0, r);
    check("bad code", 32'({r.valid, r.error}), 32'h3);
    i_host.net(bakp_pkg::NET_WR_ACCESS_KEY, bakp_pkg::ACCESS_KEY_CODE,
      r);
    i_host.net(bakp_pkg::NET_RESTORE, 32'h0, r);
    check("restore", 32'({r.valid, r.error}), 32'h2);
    idle();
    work_addr = 6'h3F;
    @(negedge clk);
    check("kept", work_rdata, 32'hA500003F);
    final_report;
  end
endmodule
